// [src/gpio_expander.sv]
`timescale 1ns/10ps
module gpio_expander
  import gpio_exp_pkg::*;
#(
  parameter int NUM_BANKS = DOC_BANKS
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_addr_sel,
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  output logic                             o_sda,
  output logic                             o_sda_oe,
  input  wire logic [NUM_BANKS*BANK_W-1:0] i_port,
  output logic      [NUM_BANKS*BANK_W-1:0] o_port,
  output logic      [NUM_BANKS*BANK_W-1:0] o_port_oe,
  output logic                             o_int_n,
  output logic                             o_int_oe
);
  localparam int LINES = NUM_BANKS * BANK_W;
  localparam int SW    = LINES + 2;

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  // The bank field is two bits and its top code is reserved
  if (NUM_BANKS < 1 || NUM_BANKS > DOC_BANKS) begin : g_bad_banks
    $error("gpio_expander: NUM_BANKS must be 1 to 3");
  end

  i2c_link_if link ();

  logic [SYNC_STAGES-1:0][SW-1:0] pin_s_r;
  logic [SW-1:0]    pin_f_r, pin_f_nxt;
  logic [LINES-1:0] live;
  logic             reset_pin_lo, strap_hi;

  logic [7:0]       cmd_r, cmd_nxt;
  logic [LINES-1:0] out_r, out_nxt;  // Per-bank register set
  logic [LINES-1:0] inv_r, inv_nxt;
  logic [LINES-1:0] dir_r, dir_nxt;
  logic [LINES-1:0] in_r, in_nxt;
  logic [2:0]       warm_r, warm_nxt;
  logic             int_r, int_nxt;
  logic [6:0]       addr_r, addr_nxt;
  logic [7:0]       rd_byte;
  logic [1:0]       ptr_bank;
  reg_type_t        ptr_type;
  logic             ptr_ok;

  // ---------------------------------------------------------------------------
  // Pin filter: three stages, a change counts when stages two and three agree
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < SW; k++) begin
      pin_f_nxt[k] = (pin_s_r[1][k] == pin_s_r[2][k]) ? pin_s_r[2][k] : pin_f_r[k];
    end
  end

  assign live         = pin_f_r[LINES-1:0];
  assign strap_hi     = pin_f_r[LINES];
  assign reset_pin_lo = ~pin_f_r[LINES+1];

  // ---------------------------------------------------------------------------
  // Pointer decode
  // ---------------------------------------------------------------------------
  assign ptr_type = reg_type_t'(cmd_r[TYPE_MSB:TYPE_LSB]);
  assign ptr_bank = cmd_r[BANK_MSB:BANK_LSB];
  assign ptr_ok   = (32'(ptr_bank) < NUM_BANKS);  // Reserved bank reads zero, takes no write

  // Pointer after one byte: with bit 7 set, low bits step and wrap inside the register type
  function automatic logic [7:0] step_ptr(input logic [7:0] cmd);
    logic [7:0] res;
    res = cmd;
    if (cmd[STEP_FLAG_BIT]) begin
      if (32'(cmd[BANK_MSB:BANK_LSB]) >= NUM_BANKS - 1) begin
        res[BANK_MSB:BANK_LSB] = 2'h0;
      end else begin
        res[BANK_MSB:BANK_LSB] = cmd[BANK_MSB:BANK_LSB] + 2'h1;
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Read data for the byte the engine is about to send
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_ok) begin
      case (ptr_type)  // Any register reads back
        REG_INPUT:  rd_byte = live[ptr_bank*BANK_W +: BANK_W]
                              ^ inv_r[ptr_bank*BANK_W +: BANK_W];
        REG_OUTPUT: rd_byte = out_r[ptr_bank*BANK_W +: BANK_W];
        REG_INVERT: rd_byte = inv_r[ptr_bank*BANK_W +: BANK_W];
        REG_DIR:    rd_byte = dir_r[ptr_bank*BANK_W +: BANK_W];
        default:    rd_byte = 8'h00;
      endcase
    end
  end

  assign link.tx_byte    = rd_byte;
  assign link.slave_addr = addr_r;
  assign link.soft_rst   = reset_pin_lo;

  // ---------------------------------------------------------------------------
  // Register file and pointer
  // ---------------------------------------------------------------------------
  always_comb begin
    cmd_nxt = cmd_r;
    out_nxt = out_r;
    inv_nxt = inv_r;
    dir_nxt = dir_r;
    in_nxt = in_r;
    warm_nxt = warm_r;
    if (reset_pin_lo) begin  // Same defaults as power-on reset
      cmd_nxt = CMD_RST;
      out_nxt = {NUM_BANKS{OUT_RST}};
      inv_nxt = {NUM_BANKS{INVERT_RST}};
      dir_nxt = {NUM_BANKS{DIR_RST}};
      warm_nxt = 3'h0;
    end else begin
      if (warm_r != WARM_CYC) begin
        warm_nxt = warm_r + 3'h1;
      end
      if (link.rx_strobe && link.rx_is_cmd) begin
        cmd_nxt = link.rx_byte;
      end else if (link.rx_strobe) begin
        if (ptr_ok) begin
          case (ptr_type)  // Input register ignores writes
            REG_OUTPUT: out_nxt[ptr_bank*BANK_W +: BANK_W] = link.rx_byte;
            REG_INVERT: inv_nxt[ptr_bank*BANK_W +: BANK_W] = link.rx_byte;
            REG_DIR:    dir_nxt[ptr_bank*BANK_W +: BANK_W] = link.rx_byte;
            default:    ;
          endcase
        end
        cmd_nxt = step_ptr(cmd_r);
      end else if (link.tx_done) begin
        cmd_nxt = step_ptr(cmd_r);
      end
    end
    // Pins are captured while the synchronisers refill after reset, then on
    // every read of an input bank; a read is what clears the interrupt
    if (reset_pin_lo || warm_r != WARM_CYC) begin
      in_nxt = live;
    end else if (link.tx_load && ptr_ok && ptr_type == REG_INPUT) begin
      in_nxt[ptr_bank*BANK_W +: BANK_W] = live[ptr_bank*BANK_W +: BANK_W];
    end
  end

  // ---------------------------------------------------------------------------
  // Change interrupt and slave address
  // ---------------------------------------------------------------------------
  always_comb begin
    // Only lines set as inputs can raise it; outputs would fire on every write
    // Held off while warming: the filters still show their reset level then
    int_nxt = |((live ^ in_r) & dir_r) & ~reset_pin_lo & (warm_r == WARM_CYC);
    addr_nxt = strap_hi ? ADDR_STRAP_HI : ADDR_STRAP_LO;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s_r <= '1;
      pin_f_r <= '1;
      cmd_r <= CMD_RST;
      out_r <= {NUM_BANKS{OUT_RST}};
      inv_r <= {NUM_BANKS{INVERT_RST}};
      dir_r <= {NUM_BANKS{DIR_RST}};
      in_r <= '1;
      warm_r <= 3'h0;
      int_r <= 1'b0;
      addr_r <= ADDR_STRAP_LO;
    end else begin
      pin_s_r <= {pin_s_r[SYNC_STAGES-2:0], {i_reset_n, i_addr_sel, i_port}};
      pin_f_r <= pin_f_nxt;
      cmd_r <= cmd_nxt;
      out_r <= out_nxt;
      inv_r <= inv_nxt;
      dir_r <= dir_nxt;
      in_r <= in_nxt;
      warm_r <= warm_nxt;
      int_r <= int_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial engine
  // ---------------------------------------------------------------------------
  i2c_slave_port u_serial (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda      (o_sda),
    .o_sda_oe   (o_sda_oe),
    .link       (link.engine)
  );

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  assign o_port    = out_r;   // Push-pull level from output register
  assign o_port_oe = ~dir_r;  // Direction bit 0 turns the driver on
  assign o_int_n   = 1'b0;    // Open drain: pulls low or floats
  assign o_int_oe  = int_r;
endmodule // gpio_expander

// [common/gpio_exp_pkg.sv]
package gpio_exp_pkg;
  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int BANK_W        = 8;
  localparam int DOC_BANKS     = 3;
  localparam int SYNC_STAGES   = 3;

  // ---------------------------------------------------------------------------
  // Serial addressing
  // ---------------------------------------------------------------------------
  localparam logic [6:0] ADDR_STRAP_LO = 7'h22;
  localparam logic [6:0] ADDR_STRAP_HI = 7'h23;
  localparam int         RW_BIT        = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------------------
  // Command byte layout
  // ---------------------------------------------------------------------------
  localparam int STEP_FLAG_BIT = 7;
  localparam int TYPE_MSB      = 3;
  localparam int TYPE_LSB      = 2;
  localparam int BANK_MSB      = 1;
  localparam int BANK_LSB      = 0;

  typedef enum logic [1:0] {
    REG_INPUT  = 2'h0,
    REG_OUTPUT = 2'h1,
    REG_INVERT = 2'h2,
    REG_DIR    = 2'h3
  } reg_type_t;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_RST    = 8'h00;
  localparam logic [7:0] OUT_RST    = 8'hFF;
  localparam logic [7:0] INVERT_RST = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'hFF;  // 1 = input
  localparam logic [2:0] WARM_CYC   = 3'h6;   // Cycles until the pin filters show real levels
endpackage

// [common/i2c_link_if.sv]
`timescale 1ns/10ps
interface i2c_link_if;
  logic [6:0] slave_addr;  // Address to answer
  logic       soft_rst;    // Reset from the reset pin
  logic [7:0] rx_byte;     // Byte received from master
  logic       rx_strobe;   // One-cycle pulse, rx_byte valid
  logic       rx_is_cmd;   // First byte after a write address
  logic [7:0] tx_byte;     // Byte offered for the next read
  logic       tx_load;     // Engine takes tx_byte this cycle
  logic       tx_done;     // Last taken byte fully shifted out

  modport engine (
    input  slave_addr, soft_rst, tx_byte,
    output rx_byte, rx_strobe, rx_is_cmd, tx_load, tx_done
  );
  modport regs (
    output slave_addr, soft_rst, tx_byte,
    input  rx_byte, rx_strobe, rx_is_cmd, tx_load, tx_done
  );
endinterface

// [src/i2c_slave_port.sv]
`timescale 1ns/10ps
module i2c_slave_port
  import gpio_exp_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda,
  output logic      o_sda_oe,
  i2c_link_if.engine link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_ADDR_ACK = 3'b011, ST_RX = 3'b010,
    ST_RX_ACK = 3'b110, ST_TX = 3'b111, ST_TX_ACK = 3'b101
  } eng_state_t;

  logic [SYNC_STAGES-1:0] scl_s_r, sda_s_r;
  logic       scl_f_r, sda_f_r, scl_q_r, sda_q_r;
  logic       scl_f_nxt, sda_f_nxt;
  eng_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic       oe_r, oe_nxt, rw_r, rw_nxt, first_r, first_nxt, ack_r, ack_nxt;
  logic       scl_rise, scl_fall, start_det, stop_det;

  // ---------------------------------------------------------------------------
  // Line filter: a level counts once the last two stages agree
  // ---------------------------------------------------------------------------
  always_comb begin
    scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
    sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
  end

  assign scl_rise  = scl_f_r & ~scl_q_r;
  assign scl_fall  = ~scl_f_r & scl_q_r;
  assign start_det = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
  assign stop_det  = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;

  // ---------------------------------------------------------------------------
  // Bit and byte sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    ack_nxt = ack_r;
    link.rx_strobe = 1'b0;
    link.tx_load = 1'b0;
    link.tx_done = 1'b0;
    if (link.soft_rst || stop_det) begin  // Pin reset restarts the sequencer
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      st_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_f_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
            if (st_r == ST_RX) begin
              oe_nxt = 1'b1;
              link.rx_strobe = 1'b1;
              st_nxt = ST_RX_ACK;
            end else if (sh_r[7:1] == link.slave_addr) begin
              oe_nxt = 1'b1;
              rw_nxt = sh_r[RW_BIT];  // 1 = read, 0 = write
              st_nxt = ST_ADDR_ACK;
            end else begin
              st_nxt = ST_IDLE;  // Not ours: stay off the bus until the next start
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            first_nxt = (st_r == ST_ADDR_ACK);
            st_nxt = ST_RX;
            if (st_r == ST_ADDR_ACK && rw_r) begin
              link.tx_load = 1'b1;
              sh_nxt = link.tx_byte;
              oe_nxt = ~link.tx_byte[7];
              st_nxt = ST_TX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BITS_PER_BYTE) begin
              oe_nxt = 1'b0;
              link.tx_done = 1'b1;
              st_nxt = ST_TX_ACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_nxt = ~sda_f_r;
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (ack_r) begin
              link.tx_load = 1'b1;
              sh_nxt = link.tx_byte;
              oe_nxt = ~link.tx_byte[7];
              st_nxt = ST_TX;
            end else begin
              st_nxt = ST_IDLE;  // Master ended the read with a NACK
            end
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_s_r <= '1;
      sda_s_r <= '1;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      scl_s_r <= {scl_s_r[SYNC_STAGES-2:0], i_scl};
      sda_s_r <= {sda_s_r[SYNC_STAGES-2:0], i_sda};
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign o_sda          = 1'b0;  // Open drain: only ever pulls low
  assign o_sda_oe       = oe_r;
  assign link.rx_byte   = sh_r;
  assign link.rx_is_cmd = first_r;
endmodule // i2c_slave_port

// [testbench/gpio_expander_assertions.sv]
`timescale 1ns/10ps
module gpio_expander_checker
  import gpio_exp_pkg::*;
#(
  parameter int NUM_BANKS = DOC_BANKS
) (
  input wire logic                        i_core_clk,
  input wire logic                        i_rst,
  input wire logic                        i_reset_n,
  input wire logic                        i_addr_sel,
  input wire logic                        i_scl,
  input wire logic                        i_sda,
  input wire logic                        o_sda,
  input wire logic                        o_sda_oe,
  input wire logic [NUM_BANKS*BANK_W-1:0] i_port,
  input wire logic [NUM_BANKS*BANK_W-1:0] o_port,
  input wire logic [NUM_BANKS*BANK_W-1:0] o_port_oe,
  input wire logic                        o_int_n,
  input wire logic                        o_int_oe
);
  localparam int W = NUM_BANKS*BANK_W;
  // ----------
  // Port checks
  // ----------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Quiet windows, long enough to outlast the input filters
  sequence scl_high_s;
    i_scl[*6];
  endsequence
  sequence pins_calm_s;
    ($stable(i_port) && $stable(o_port_oe))[*8];
  endsequence
  sequence bus_idle_s;
    (i_scl && i_reset_n)[*8];
  endsequence
  AST_OPEN_DRAIN: assert property (o_int_n == 1'b0 && o_sda == 1'b0)
    else $error("open drain value not low");
  AST_HARD_RST: assert property ($fell(i_rst) |-> o_port == {W{1'b1}} && o_port_oe == '0)
    else $error("defaults missing after reset");
  AST_SOFT_RST: assert property ((!i_reset_n)[*6] |-> o_port_oe == '0 && !o_int_oe)
    else $error("reset pin did not restore defaults");
  AST_SDA_STEADY: assert property (scl_high_s |-> $stable(o_sda_oe))
    else $error("sda drive moved while scl high");
  AST_SDA_RISE: assert property ($rose(o_sda_oe) |-> !i_scl && $past(i_scl, 3) == 1'b0)
    else $error("sda drive began outside scl low");
  AST_INT_OUTPUTS: assert property ((&o_port_oe)[*6] |-> !o_int_oe)
    else $error("interrupt with no input lines");
  AST_INT_QUIET: assert property (pins_calm_s |=> !$rose(o_int_oe))
    else $error("interrupt rose without pin change");
  AST_PORT_QUIET: assert property (bus_idle_s |=> $stable(o_port) && $stable(o_port_oe))
    else $error("port changed with bus idle");
endmodule // gpio_expander_checker

bind gpio_expander gpio_expander_checker #(.NUM_BANKS(NUM_BANKS)) u_gpio_expander_checker (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_addr_sel(i_addr_sel),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_port(i_port),
  .o_port(o_port), .o_port_oe(o_port_oe), .o_int_n(o_int_n), .o_int_oe(o_int_oe)
);

// [testbench/i2c_master_model.sv]
`timescale 1ns/10ps
module i2c_master_model (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Clock stands high and data is released between frames
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // One bit: data moves mid-low, sampled mid-high where the slave holds it
  task automatic bit_x(input logic b, output logic r);
    o_scl <= 1'b0;
    wt(6);
    o_sda_low <= ~b;
    wt(6);
    o_scl <= 1'b1;
    wt(6);
    r = i_sda;
    wt(6);
  endtask
  // Serves as first and repeated start alike
  task automatic start();
    o_scl <= 1'b0;
    wt(6);
    o_sda_low <= 1'b0;
    wt(6);
    o_scl <= 1'b1;
    wt(12);
    o_sda_low <= 1'b1;
    wt(12);
  endtask
  task automatic stop();
    o_scl <= 1'b0;
    wt(6);
    o_sda_low <= 1'b1;
    wt(6);
    o_scl <= 1'b1;
    wt(12);
    o_sda_low <= 1'b0;
    wt(12);
  endtask
  // Byte out, MSB first; the ninth bit is released for the slave
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, r);
  endtask
endmodule // i2c_master_model

// [testbench/gpio_expander_tb.sv]
`timescale 1ns/10ps
module gpio_expander_tb;
  import gpio_exp_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        reset_n;
  logic        addr_sel;
  logic        scl;
  logic        sda_low;
  logic        sda_oe;
  logic        int_oe;
  logic [23:0] ext;
  logic [23:0] port_out;
  logic [23:0] port_oe;
  logic [6:0]  dev_addr;
  logic [7:0]  m_reg [4][3];
  int          err_count;
  int          total_checks;
  // Pull-ups on the bus; driven port lines show the device's level
  wire         sda  = ~(sda_low | sda_oe);
  wire  [23:0] pins = (port_oe & port_out) | (~port_oe & ext);

  always #20 core_clk = ~core_clk;

  gpio_expander u_gpio_expander (
    .i_core_clk(core_clk), .i_rst(rst), .i_reset_n(reset_n), .i_addr_sel(addr_sel),
    .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe), .i_port(pins),
    .o_port(port_out), .o_port_oe(port_oe), .o_int_n(), .o_int_oe(int_oe)
  );
  i2c_master_model u_i2c_master_model (
    .i_core_clk(core_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
  );

  // ----------
  // Reference model and checks
  // ----------
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic model_reset();
    for (int b = 0; b < 3; b++) begin
      m_reg[0][b] = pins[b*8 +: 8];
      m_reg[1][b] = OUT_RST;
      m_reg[2][b] = INVERT_RST;
      m_reg[3][b] = DIR_RST;
    end
  endtask
  // Reading an input bank recaptures it, which is what clears the interrupt
  function automatic logic [7:0] model_rd(input logic [1:0] t, input logic [1:0] b);
    if (t == 2'h0) begin
      m_reg[0][b] = pins[b*8 +: 8];
      return pins[b*8 +: 8] ^ m_reg[2][b];
    end
    return m_reg[t][b];
  endfunction
  function automatic logic int_exp();
    logic [23:0] dirv;
    logic [23:0] inr;
    dirv = {m_reg[3][2], m_reg[3][1], m_reg[3][0]};
    inr = {m_reg[0][2], m_reg[0][1], m_reg[0][0]};
    return |(dirv & (pins ^ inr));
  endfunction
  // Command then n data bytes; dv below zero asks for random write data
  task automatic xfer(input logic [7:0] cmd, input int n, input logic rd, input int dv);
    logic       a;
    logic [7:0] d;
    logic [1:0] b;
    b = cmd[1:0];
    @(posedge core_clk);
    u_i2c_master_model.start();
    u_i2c_master_model.wr({dev_addr, 1'b0}, a);
    chk_val(24'(a), 24'h000001, "write address ack");
    u_i2c_master_model.wr(cmd, a);
    if (rd) begin
      u_i2c_master_model.start();
      u_i2c_master_model.wr({dev_addr, 1'b1}, a);
    end
    for (int i = 0; i < n; i++) begin
      if (rd) begin
        u_i2c_master_model.rd(i < n - 1, d);
        chk_val(24'(d), 24'(model_rd(cmd[3:2], b)), "read byte");
      end else begin
        d = (dv < 0) ? 8'($urandom) : 8'(dv);
        u_i2c_master_model.wr(d, a);
        if (cmd[3:2] != 2'h0) m_reg[cmd[3:2]][b] = d;
      end
      if (cmd[7]) b = (b == 2'h2) ? 2'h0 : b + 2'h1;
    end
    u_i2c_master_model.stop();
  endtask
  task automatic chk_port();
    @(negedge core_clk);
    chk_val(port_out, {m_reg[1][2], m_reg[1][1], m_reg[1][0]}, "port level");
    chk_val(port_oe, ~{m_reg[3][2], m_reg[3][1], m_reg[3][0]}, "port drive");
    chk_val(24'(int_oe), 24'(int_exp()), "interrupt");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------
  // Main sequence
  // ----------
  initial begin
    logic a;
    core_clk = 1'b0;
    rst = 1'b1;
    reset_n = 1'b1;
    addr_sel = 1'b0;
    err_count = 0;
    total_checks = 0;
    dev_addr = ADDR_STRAP_LO;
    void'($urandom(32'hB1E6));
    ext = 24'($urandom);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    model_reset();
    chk_port();
    xfer(8'h8C, 3, 1'b1, 0);
    $display("test reset defaults done");
    // Each strap level answers exactly one of the two addresses
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      addr_sel <= s[0];
      repeat (8) @(posedge core_clk);
      for (int k = 0; k < 2; k++) begin
        u_i2c_master_model.start();
        u_i2c_master_model.wr({7'h22 + 7'(k), 1'b0}, a);
        chk_val(24'(a), 24'(k == s), "strap ack");
        u_i2c_master_model.stop();
      end
    end
    dev_addr = ADDR_STRAP_HI;
    $display("test address strap done");
    // Four bytes with stepping wrap onto bank 0; input writes are ignored
    for (int t = 1; t < 4; t++) xfer(8'h80 | 8'(t << 2), 4, 1'b0, -1);
    xfer(8'h80, 2, 1'b0, -1);
    chk_port();
    $display("test register writes done");
    for (int t = 3; t >= 0; t--) xfer(8'h80 | 8'(t << 2), 3, 1'b1, 0);
    xfer(8'h09, 2, 1'b1, 0);
    chk_port();
    $display("test readback done");
    @(posedge core_clk);
    ext <= ~ext;
    repeat (10) @(posedge core_clk);
    chk_port();
    xfer(8'h80, 3, 1'b1, 0);
    chk_port();
    xfer(8'h8C, 3, 1'b0, 0);
    ext <= ~ext;
    repeat (10) @(posedge core_clk);
    chk_port();
    $display("test interrupt done");
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    model_reset();
    chk_port();
    xfer(8'h84, 3, 1'b1, 0);
    $display("test reset pin done");
    test_done();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    $display("wrong value at %0t: run hung", $time);
    test_done();
  end
endmodule // gpio_expander_tb
